// *** rtl/codec_port_pkg.sv ***
/*
 * Shared constants for the codec serial frame port: frame geometry,
 * register offsets, field positions, reset values and transfer states.
 * Assumes a single 25 MHz core clock drives all logic that uses it.
 */
`default_nettype none

package codec_port_pkg;
    // Frame geometry in shift-clock periods
    localparam int         FRAME_SCLKS  = 256;
    localparam int         SLOT_BITS    = 16;
    localparam logic [7:0] SLOT_LEN     = 8'h10;
    localparam logic [7:0] SEC_SLOT_POS = 8'h80;

    // Master shift clock half period in core clock cycles
    localparam int         SCLK_HALF_DEF = 4;

    // Register map
    localparam int         ADDR_W       = 3;
    localparam int         DATA_W       = 16;
    localparam logic [2:0] ADDR_CTRL2   = 3'h0;
    localparam logic [2:0] ADDR_CTRL3   = 3'h1;
    localparam logic [2:0] ADDR_TX_PRI  = 3'h2;
    localparam logic [2:0] ADDR_TX_SEC  = 3'h3;
    localparam logic [2:0] ADDR_RX_PRI  = 3'h4;
    localparam logic [2:0] ADDR_RX_SEC  = 3'h5;
    localparam logic [2:0] ADDR_STATUS  = 3'h6;

    // Field positions
    localparam int         CTRL2_FLAG_BIT  = 0;
    localparam int         CTRL2_PHONE_BIT = 1;

    // Reset values
    localparam logic [1:0]  CTRL2_RST = 2'h0;
    localparam logic [7:0]  CTRL3_RST = 8'h10;
    localparam logic [15:0] WORD_RST  = 16'h0000;

    typedef enum logic [1:0] {
        XFER_IDLE = 2'b00,
        XFER_PRI  = 2'b01,
        XFER_SEC  = 2'b10
    } xfer_e;
endpackage

`default_nettype wire

// *** rtl/codec_serial_frame_port.sv ***
/*
 * Serial host port and frame timing of a voice codec: master/slave role,
 * frame sync generation or detection, delayed frame sync for chained
 * slaves, shift clock generation, 16-bit primary and secondary slots,
 * request latch, phone-mode flag and power-down.
 * Assumes the register port is synchronous to the core clock, the other pins asynchronous to it, and
 * that a slave-role shift clock is at most a quarter of the core clock.
 */
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module codec_serial_frame_port #(
    parameter int SCLK_HALF = codec_port_pkg::SCLK_HALF_DEF
) (
    input  wire logic        core_clk_in,              // 25 MHz core clock
    input  wire logic        nrst_in,                  // Async reset, active low
    input  wire logic [2:0]  reg_addr_in,              // Register index
    input  wire logic [15:0] reg_wdata_in,             // Write data
    input  wire logic        reg_wr_in,                // Write strobe
    input  wire logic        reg_rd_in,                // Read strobe
    output logic      [15:0] reg_rdata_out,            // Read data, cycle after strobe
    input  wire logic        role_select_in,           // High: master
    input  wire logic        power_down_n_in,          // Low: power down
    input  wire logic        secondary_request_in,     // Secondary transfer request
    input  wire logic        shift_clock_in,           // Shift clock pin level
    output logic             shift_clock_out,          // Shift clock drive
    output logic             shift_clock_oe_out,       // Shift clock enable
    input  wire logic        frame_sync_n_in,          // Frame sync pin level
    output logic             frame_sync_n_out,         // Frame sync drive
    output logic             frame_sync_oe_out,        // Frame sync enable
    output logic             delayed_frame_sync_n_out, // Frame sync for chained slave
    input  wire logic        serial_data_in,           // Serial data from host
    output logic             serial_data_out,          // Serial data to host
    output logic             serial_data_oe_out,       // Serial data enable
    output logic             user_flag_out             // Phone-mode flag
);
    localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

    logic [1:0] rst_pipe;
    logic       rst_n;
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;

    // Reset release and pin synchronisers
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rst_pipe <= 2'h0;
        end
        else
        begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1 <= 6'h22;
            pin_s2 <= 6'h22;
        end
        else
        begin
            pin_s1 <= {power_down_n_in, role_select_in, secondary_request_in,
                       serial_data_in, frame_sync_n_in, shift_clock_in};
            pin_s2 <= pin_s1;
        end
    end

    logic role_m;
    logic pd_act;
    assign role_m = pin_s2[4];
    assign pd_act = !pin_s2[5];

    codec_port_pkg::xfer_e xfer_reg, xfer_next;
    logic [7:0]  div_reg, div_next, pos_reg, pos_next, ctrl3_reg, ctrl3_next;
    logic [1:0]  ctrl2_reg, ctrl2_next;
    logic [15:0] tx_pri_reg, tx_pri_next, tx_sec_reg, tx_sec_next;
    logic [15:0] rx_pri_reg, rx_pri_next, rx_sec_reg, rx_sec_next;
    logic [15:0] tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next, rdata_next;
    logic sclk_reg, sclk_next, sclk_prev_reg, fs_reg, fs_next, fsd_reg, fsd_next;
    logic low_prev_reg, dout_reg, dout_next, oe_reg, oe_next;
    logic sec_serve_reg, sec_serve_next, sec_frame_reg, sec_frame_next;
    logic flag_reg, flag_next, role_oe_reg;
    logic rise, fall, low_now, start, stop, sec_k;

    function automatic logic in_slot(input logic [7:0] p, input logic sec);
        logic [7:0] q;
        q = p - codec_port_pkg::SEC_SLOT_POS;
        return (p < codec_port_pkg::SLOT_LEN) || (sec && (q < codec_port_pkg::SLOT_LEN));
    endfunction

    always_comb
    begin
        div_next       = div_reg;
        sclk_next      = sclk_reg;
        pos_next       = pos_reg;
        fs_next        = fs_reg;
        fsd_next       = fsd_reg;
        xfer_next      = xfer_reg;
        tx_sh_next     = tx_sh_reg;
        rx_sh_next     = rx_sh_reg;
        rx_pri_next    = rx_pri_reg;
        rx_sec_next    = rx_sec_reg;
        dout_next      = dout_reg;
        sec_serve_next = sec_serve_reg;
        sec_frame_next = sec_frame_reg;
        rise           = 1'b0;
        fall           = 1'b0;
        // Master divides the core clock; slave finds edges of the pin
        if (role_m)
        begin
            if (!pd_act)
            begin
                div_next = div_reg + 8'h01;
                if (div_reg == HALF_LAST)
                begin
                    div_next  = 8'h00;
                    sclk_next = !sclk_reg;
                    rise      = !sclk_reg;
                    fall      = sclk_reg;
                end
            end
        end
        else
        begin
            rise = pin_s2[0] && !sclk_prev_reg;
            fall = !pin_s2[0] && sclk_prev_reg;
        end
        // Frame position, master frame sync and delayed frame sync
        if (rise)
        begin
            pos_next = pos_reg + 8'h01;
            if (pos_reg == 8'h00)
            begin
                sec_frame_next = sec_serve_reg;
            end
            if (role_m)
            begin
                fs_next = !in_slot(pos_reg, sec_frame_reg);
            end
            fsd_next = !in_slot(pos_reg - ctrl3_reg, sec_frame_reg);
        end
        low_now = role_m ? !fs_next : !pin_s2[1];
        start   = low_now && !low_prev_reg;
        stop    = !low_now && low_prev_reg;
        sec_k   = role_m ? (pos_reg != 8'h00) : sec_serve_reg;
        if (start && !role_m && !sec_k)
        begin
            pos_next       = 8'h00;
            sec_frame_next = sec_serve_reg;
        end
        // Shifting: launch on rising, capture on falling edges
        if (start)
        begin
            xfer_next  = sec_k ? codec_port_pkg::XFER_SEC : codec_port_pkg::XFER_PRI;
            tx_sh_next = sec_k ? {tx_sec_reg[14:0], 1'b0} : {tx_pri_reg[14:0], 1'b0};
            dout_next  = sec_k ? tx_sec_reg[15] : tx_pri_reg[15];
        end
        else if (rise && low_now)
        begin
            dout_next  = tx_sh_reg[15];
            tx_sh_next = {tx_sh_reg[14:0], 1'b0};
        end
        if (fall && low_now)
        begin
            rx_sh_next = {rx_sh_reg[14:0], pin_s2[2]};
        end
        if (stop)
        begin
            xfer_next = codec_port_pkg::XFER_IDLE;
            if (xfer_reg == codec_port_pkg::XFER_PRI)
            begin
                rx_pri_next    = rx_sh_reg;
                sec_serve_next = sec_serve_reg || pin_s2[3];
            end
            else if (xfer_reg == codec_port_pkg::XFER_SEC)
            begin
                rx_sec_next    = rx_sh_reg;
                sec_serve_next = 1'b0;
            end
        end
        oe_next = low_now;
        // Power-down clears counters and stops the port, registers stay
        if (pd_act)
        begin
            div_next  = 8'h00;
            sclk_next = 1'b0;
            pos_next  = 8'h00;
            fs_next   = 1'b1;
            fsd_next  = 1'b1;
            xfer_next = codec_port_pkg::XFER_IDLE;
            oe_next   = 1'b0;
        end
    end

    // Software registers
    always_comb
    begin
        ctrl2_next  = ctrl2_reg;
        ctrl3_next  = ctrl3_reg;
        tx_pri_next = tx_pri_reg;
        tx_sec_next = tx_sec_reg;
        rdata_next  = 16'h0000;
        if (reg_wr_in)
        begin
            case (reg_addr_in)
                codec_port_pkg::ADDR_CTRL2:  ctrl2_next  = reg_wdata_in[1:0];
                codec_port_pkg::ADDR_CTRL3:  ctrl3_next  = reg_wdata_in[7:0];
                codec_port_pkg::ADDR_TX_PRI: tx_pri_next = reg_wdata_in;
                codec_port_pkg::ADDR_TX_SEC: tx_sec_next = reg_wdata_in;
                default:                     ctrl2_next  = ctrl2_reg;
            endcase
        end
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                codec_port_pkg::ADDR_CTRL2:  rdata_next = {14'h0000, ctrl2_reg};
                codec_port_pkg::ADDR_CTRL3:  rdata_next = {8'h00, ctrl3_reg};
                codec_port_pkg::ADDR_TX_PRI: rdata_next = tx_pri_reg;
                codec_port_pkg::ADDR_TX_SEC: rdata_next = tx_sec_reg;
                codec_port_pkg::ADDR_RX_PRI: rdata_next = rx_pri_reg;
                codec_port_pkg::ADDR_RX_SEC: rdata_next = rx_sec_reg;
                codec_port_pkg::ADDR_STATUS:
                    rdata_next = {12'h000, pd_act, role_m, sec_frame_reg, sec_serve_reg};
                default:                     rdata_next = 16'h0000;
            endcase
        end
        flag_next = ctrl2_reg[codec_port_pkg::CTRL2_PHONE_BIT]
                    && ctrl2_reg[codec_port_pkg::CTRL2_FLAG_BIT];
    end

    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xfer_reg      <= codec_port_pkg::XFER_IDLE;
            div_reg       <= 8'h00;
            pos_reg       <= 8'h00;
            ctrl2_reg     <= codec_port_pkg::CTRL2_RST;
            ctrl3_reg     <= codec_port_pkg::CTRL3_RST;
            tx_pri_reg    <= codec_port_pkg::WORD_RST;
            tx_sec_reg    <= codec_port_pkg::WORD_RST;
            rx_pri_reg    <= codec_port_pkg::WORD_RST;
            rx_sec_reg    <= codec_port_pkg::WORD_RST;
            tx_sh_reg     <= codec_port_pkg::WORD_RST;
            rx_sh_reg     <= codec_port_pkg::WORD_RST;
            reg_rdata_out <= 16'h0000;
            sclk_reg      <= 1'b0;
            sclk_prev_reg <= 1'b0;
            fs_reg        <= 1'b1;
            fsd_reg       <= 1'b1;
            low_prev_reg  <= 1'b0;
            dout_reg      <= 1'b0;
            oe_reg        <= 1'b0;
            sec_serve_reg <= 1'b0;
            sec_frame_reg <= 1'b0;
            flag_reg      <= 1'b0;
            role_oe_reg   <= 1'b0;
        end
        else
        begin
            xfer_reg      <= xfer_next;
            div_reg       <= div_next;
            pos_reg       <= pos_next;
            ctrl2_reg     <= ctrl2_next;
            ctrl3_reg     <= ctrl3_next;
            tx_pri_reg    <= tx_pri_next;
            tx_sec_reg    <= tx_sec_next;
            rx_pri_reg    <= rx_pri_next;
            rx_sec_reg    <= rx_sec_next;
            tx_sh_reg     <= tx_sh_next;
            rx_sh_reg     <= rx_sh_next;
            reg_rdata_out <= rdata_next;
            sclk_reg      <= sclk_next;
            sclk_prev_reg <= pin_s2[0];
            fs_reg        <= fs_next;
            fsd_reg       <= fsd_next;
            low_prev_reg  <= pd_act ? 1'b0 : low_now;
            dout_reg      <= dout_next;
            oe_reg        <= oe_next;
            sec_serve_reg <= sec_serve_next;
            sec_frame_reg <= sec_frame_next;
            flag_reg      <= flag_next;
            role_oe_reg   <= role_m;
        end
    end

    assign shift_clock_out          = sclk_reg;
    assign shift_clock_oe_out       = role_oe_reg;
    assign frame_sync_n_out         = fs_reg;
    assign frame_sync_oe_out        = role_oe_reg;
    assign delayed_frame_sync_n_out = fsd_reg;
    assign serial_data_out          = dout_reg;
    assign serial_data_oe_out       = oe_reg;
    assign user_flag_out            = flag_reg;

    // Helper counters for checks
    logic [4:0] lowcnt;
    logic [8:0] percnt;
    logic [7:0] lagcnt;
    logic       lag_ok;
    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lowcnt <= 5'h00;
            percnt <= 9'h000;
            lagcnt <= 8'h00;
            lag_ok <= 1'b0;
        end
        else
        begin
            lowcnt <= start ? 5'h01 : ((rise && low_prev_reg) ? lowcnt + 5'h01 : lowcnt);
            // Power-down restarts the frame, so the spacing count restarts too
            percnt <= pd_act ? 9'h000
                    : ((start && !sec_k) ? 9'h001 : (rise ? percnt + 9'h001 : percnt));
            lagcnt <= (start && !sec_k) ? 8'h00 : (rise ? lagcnt + 8'h01 : lagcnt);
            // Lag is only meaningful when the delay setting held since frame start
            lag_ok <= (start && !sec_k) || (lag_ok && (ctrl3_next == ctrl3_reg));
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n);

    a_fs_low_width: assert property (role_m && !pd_act && stop |-> lowcnt == 5'h10)
        else $error("master frame sync low width is not 16 shift clocks");
    a_frame_spacing: assert property (role_m && start && !sec_k && percnt != 9'h000
        |-> percnt == 9'h100)
        else $error("primary frame syncs not 256 shift clocks apart");
    a_fsd_lag: assert property (role_m && $fell(fsd_reg) && lag_ok
        && ctrl3_reg > 8'h10 && ctrl3_reg < 8'h70
        |-> lagcnt == ctrl3_reg || lagcnt == ctrl3_reg + 8'h80)
        else $error("delayed frame sync lag differs from programmed count");
    a_req_latch: assert property (stop && xfer_reg == codec_port_pkg::XFER_PRI
        && pin_s2[3] |=> sec_serve_reg)
        else $error("request not latched at end of primary transfer");
    a_sec_clear: assert property (stop && xfer_reg == codec_port_pkg::XFER_SEC
        |=> !sec_serve_reg)
        else $error("served request not cleared");
    a_flag_phone: assert property (!ctrl2_reg[codec_port_pkg::CTRL2_PHONE_BIT]
        |=> ##1 !user_flag_out || ctrl2_reg[codec_port_pkg::CTRL2_PHONE_BIT])
        else $error("flag driven outside phone mode");
    a_dout_hiz: assert property (!low_prev_reg && !start |=> !serial_data_oe_out)
        else $error("serial data driven outside its slot");
    a_pd_halt: assert property (pd_act ##1 pd_act |-> pos_reg == 8'h00
        && frame_sync_n_out && !shift_clock_out && !serial_data_oe_out)
        else $error("port active during power down");
    a_pd_keep: assert property (pd_act && !reg_wr_in |=> $stable(ctrl3_reg)
        && $stable(ctrl2_reg))
        else $error("power down altered a register");
    a_fs_dir: assert property (role_m ##1 role_m |-> frame_sync_oe_out
        && shift_clock_oe_out)
        else $error("frame sync not driven in master role");

    c_secondary: cover property (stop && xfer_reg == codec_port_pkg::XFER_SEC);
    c_slave_start: cover property (!role_m && start);
    c_fsd_fall: cover property ($fell(fsd_reg));
    c_power_down: cover property (pd_act && xfer_reg != codec_port_pkg::XFER_IDLE);
endmodule

`default_nettype wire

// *** verif/dsp_host_model.sv ***
/*
 * Host model: sends a word MSB first on rising shift clock, captures the
 * device word on falling shift clock while frame sync is low, and in the
 * slave role makes one frame with a 320 ns shift clock.
 * Assumes the bench resolves the shared pins from the enables.
 */
`timescale 1ns/1ns
`default_nettype none

module dsp_host_model (
    input  wire logic        sclk_in,     // Shift clock pin
    input  wire logic        fs_n_in,     // Frame sync pin
    input  wire logic        dout_in,     // Device data pin
    input  wire logic [15:0] word_in,     // Word to send
    input  wire logic        go_in,       // Start one slave-role frame
    output logic             sclk_out,    // Shift clock drive
    output logic             fs_n_out,    // Frame sync drive
    output logic             din_out,     // Data to device
    output logic      [15:0] rx_word_out, // Last word captured
    output logic      [7:0]  rx_cnt_out   // Words captured
);
    logic [15:0] sh = 16'h0000;
    int          tx_i = 0;
    int          rx_i = 0;

    initial
    begin
        sclk_out = 1'b0;
        fs_n_out = 1'b1;
        din_out = 1'b0;
        rx_word_out = 16'h0000;
        rx_cnt_out = 8'h00;
    end

    always @(negedge fs_n_in)
        din_out = word_in[15];

    // Outside a frame the data line shows the inverse of its last bit
    always @(posedge fs_n_in)
    begin
        tx_i = 0;
        rx_i = 0;
        din_out = ~din_out;
    end

    always @(posedge sclk_in)
    begin
        #1;
        if (fs_n_in == 1'b0 && tx_i < 16)
        begin
            din_out = word_in[15 - tx_i];
            tx_i++;
        end
    end

    always @(negedge sclk_in)
    begin
        if (fs_n_in == 1'b0 && rx_i < 16)
        begin
            sh = {sh[14:0], dout_in};
            rx_i++;
            if (rx_i == 16)
            begin
                rx_word_out = sh;
                rx_cnt_out++;
            end
        end
    end

    // Slave-role frame: frame sync falls with the first rising shift clock and
    // rises with the seventeenth; the clock stands low outside it
    always @(posedge go_in)
    begin
        #5 fs_n_out = 1'b0;
        sclk_out = 1'b1;
        repeat (16)
        begin
            #160 sclk_out = 1'b0;
            #160 sclk_out = 1'b1;
        end
        fs_n_out = 1'b1;
        #160 sclk_out = 1'b0;
    end
endmodule

`default_nettype wire

// *** verif/codec_serial_frame_port_test.sv ***
/*
 * Bench for the codec serial frame port: register access, frame timing,
 * secondary slot, phone flag, power-down and slave role.
 * Assumes a shift clock half period of 4 core cycles.
 */
`timescale 1ns/1ns
`default_nettype none

module codec_serial_frame_port_test;
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    logic        role = 1'b1, pdn = 1'b1, req = 1'b0, go = 1'b0, dout_last = 1'b0;
    logic        sclk_o, sclk_oe, fs_o, fs_oe, fsd_n, dout, dout_oe, flag;
    logic        p_sclk, p_fs, p_din;
    logic [2:0]  addr = 3'h0;
    logic [15:0] wdata = 16'h0000, hword = 16'h0000, tx, rdata, p_word;
    logic [7:0]  p_cnt, lag;
    logic [31:0] seed = 32'h0000_fa5c;
    wire  logic  sclk = sclk_oe ? sclk_o : p_sclk;
    wire  logic  fs = fs_oe ? fs_o : p_fs;
    wire  logic  dpin = dout_oe ? dout : ~dout_last;
    int          err_count = 0, num_checks = 0, cyc = 0, sclk_cnt = 0, n, k;
    logic [15:0] rd_q[$];
    logic [15:0] w_q[$];

    codec_serial_frame_port #(.SCLK_HALF(4)) DUT (
        .core_clk_in(clk), .nrst_in(nrst), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .role_select_in(role),
        .power_down_n_in(pdn), .secondary_request_in(req), .shift_clock_in(sclk),
        .shift_clock_out(sclk_o), .shift_clock_oe_out(sclk_oe), .frame_sync_n_in(fs),
        .frame_sync_n_out(fs_o), .frame_sync_oe_out(fs_oe),
        .delayed_frame_sync_n_out(fsd_n), .serial_data_in(p_din),
        .serial_data_out(dout), .serial_data_oe_out(dout_oe), .user_flag_out(flag));

    dsp_host_model host (
        .sclk_in(sclk), .fs_n_in(fs), .dout_in(dpin), .word_in(hword), .go_in(go),
        .sclk_out(p_sclk), .fs_n_out(p_fs), .din_out(p_din), .rx_word_out(p_word),
        .rx_cnt_out(p_cnt));

    always #20 clk = ~clk;
    always @(posedge sclk) sclk_cnt++;
    always @(p_cnt) if (w_q.size() > 0) cmp(p_word, w_q.pop_front());

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        rd_d <= rd;
        if (dout_oe) dout_last <= dout;
        if (rd_d) cmp(rdata, rd_q.pop_front());
        if (cyc == 60000) hang();
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // sel 0: frame sync level, 1: delayed frame sync level, 2: host queue empty
    task automatic wait_pin(input int sel, input logic lvl);
        int i;
        for (i = 0; i < 6000; i++)
        begin
            @(posedge clk);
            if (sel == 2 ? w_q.size() == 0 : ((sel == 1 ? fsd_n : fs) === lvl)) break;
        end
        if (i == 6000) hang();
    endtask

    task automatic frame_check(input logic [15:0] w);
        int t0, s0, t1;
        wait_pin(0, 1'b1);
        w_q.push_back(w);
        wait_pin(0, 1'b0);
        t0 = cyc;
        s0 = sclk_cnt;
        wait_pin(0, 1'b1);
        cmp(16'(cyc - t0), 16'd128);
        wait_pin(1, 1'b0);
        t1 = cyc;
        cmp(16'(t1 - t0), 16'(int'(lag) * 8));
        wait_pin(1, 1'b1);
        cmp(16'(cyc - t1), 16'd128);
        wait_pin(0, 1'b0);
        cmp(16'(cyc - t0), 16'd2048);
        cmp(16'(sclk_cnt - s0), 16'd256);
    endtask

    task automatic hang();
        err_count++;
        close_out();
    endtask

    task automatic close_out();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        rd_reg(codec_port_pkg::ADDR_CTRL2, 16'h0000);
        rd_reg(codec_port_pkg::ADDR_CTRL3, 16'h0010);
        rd_reg(3'h7, 16'h0000);
        cmp({14'h0000, fs_oe, sclk_oe}, 16'h0003);
        repeat (16) seed = lfsr(seed);
        tx = seed[15:0];
        lag = 8'h11 + {2'b00, seed[21:16]};
        repeat (16) seed = lfsr(seed);
        hword <= seed[15:0];
        wr_reg(codec_port_pkg::ADDR_TX_PRI, tx);
        wr_reg(codec_port_pkg::ADDR_TX_SEC, ~tx);
        wr_reg(codec_port_pkg::ADDR_CTRL3, {8'h00, lag});
        for (int m = 0; m < 4; m++)
        begin
            wr_reg(codec_port_pkg::ADDR_CTRL2, 16'(m));
            repeat (3) @(posedge clk);
            cmp({15'h0000, flag}, {15'h0000, m == 3});
        end
        frame_check(tx);
        rd_reg(codec_port_pkg::ADDR_RX_PRI, hword);
        req <= 1'b1;
        wait_pin(0, 1'b1);
        wait_pin(0, 1'b0);
        wait_pin(0, 1'b1);
        req <= 1'b0;
        w_q.push_back(~tx);
        w_q.push_back(tx);
        wait_pin(2, 1'b0);
        repeat (10) @(posedge clk);
        rd_reg(codec_port_pkg::ADDR_RX_SEC, hword);
        wait_pin(0, 1'b0);
        wait_pin(0, 1'b1);
        rd_reg(codec_port_pkg::ADDR_STATUS, 16'h0004);
        pdn <= 1'b0;
        repeat (40) @(posedge clk);
        n = sclk_cnt;
        k = 0;
        repeat (2500)
        begin
            @(posedge clk);
            if (fs !== 1'b1) k++;
        end
        cmp(16'(sclk_cnt - n + k), 16'h0000);
        rd_reg(codec_port_pkg::ADDR_CTRL3, {8'h00, lag});
        rd_reg(codec_port_pkg::ADDR_STATUS, 16'h000c);
        pdn <= 1'b1;
        frame_check(tx);
        role <= 1'b0;
        repeat (16) seed = lfsr(seed);
        hword <= seed[15:0];
        repeat (10) @(posedge clk);
        cmp({14'h0000, fs_oe, sclk_oe}, 16'h0000);
        w_q.push_back(tx);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wait_pin(2, 1'b0);
        repeat (10) @(posedge clk);
        rd_reg(codec_port_pkg::ADDR_RX_PRI, hword);
        close_out();
    end
endmodule

`default_nettype wire
